// *** pbmux_pkg.sv ***
// Package with register map, bit positions and pin indices of the port B mux.
package pbmux_pkg;
    // ==========================================================
    // Register byte offsets.
    localparam logic [7:0] PBMUX_OFF_MCU_CONTROL = 8'h00;
    localparam logic [7:0] PBMUX_OFF_DIR = 8'h04;
    localparam logic [7:0] PBMUX_OFF_OUT = 8'h08;
    localparam logic [7:0] PBMUX_OFF_IN = 8'h0c;
    localparam logic [7:0] PBMUX_OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] PBMUX_OFF_IRQ_MASK = 8'h14;
    // ==========================================================
    // Field layout and reset values.
    localparam int PBMUX_BIT_PULLUP_DISABLE = 4;
    localparam int PBMUX_BIT_VECTOR_SELECT = 1;
    localparam int PBMUX_BIT_VECTOR_UNLOCK = 0;
    localparam logic [7:0] PBMUX_MCU_WMASK = 8'h13;
    localparam logic [7:0] PBMUX_MCU_RESET = 8'h00;
    localparam logic [7:0] PBMUX_BYTE_RESET = 8'h00;
    localparam logic [31:0] PBMUX_WORD_ZERO = 32'h0000_0000;
    // ==========================================================
    // Pin indices.
    localparam int PBMUX_PIN_OSC_OUT = 7;
    localparam int PBMUX_PIN_OSC_IN = 6;
    localparam int PBMUX_PIN_SCK = 5;
    localparam int PBMUX_PIN_MISO = 4;
    localparam int PBMUX_PIN_MOSI = 3;
    localparam int PBMUX_PIN_SEL = 2;
    localparam int PBMUX_PIN_CMP1A = 1;
    localparam int PBMUX_NUM_PINS = 8;

    // All state of the mux top.
    typedef struct packed {
        logic [7:0] mcu;
        logic [7:0] dir;
        logic [7:0] out;
        logic [7:0] pin;
        logic [7:0] irq_sts;
        logic [7:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] pad_oe;
        logic [7:0] pad_out;
        logic [7:0] pad_pu;
        logic irq;
        logic spi_slave_active;
    } pbmux_state_t;
endpackage

// *** pbmux_top.sv ***
// Port B alternate function multiplexer with APB register file.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
module pbmux_top
    import pbmux_pkg::*;
(
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock source and timer oscillator selection.
    input wire logic clk_src_int_rc,
    input wire logic clk_src_ext_clock,
    input wire logic async_timer_select,
    input wire logic external_timer_clock_select,
    // SPI controls and data.
    input wire logic spi_enable,
    input wire logic spi_master,
    input wire logic spi_sck_out,
    input wire logic spi_slave_out,
    input wire logic spi_master_out,
    // Timer compare outputs.
    input wire logic timer2_cmp_a_en,
    input wire logic timer2_cmp_a_out,
    input wire logic timer1_cmp_b_en,
    input wire logic timer1_cmp_b_out,
    input wire logic timer1_cmp_a_en,
    input wire logic timer1_cmp_a_out,
    // Pads.
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup,
    // Pin-change sources, SPI activity and interrupt.
    output logic [7:0] pin_change_src,
    output logic spi_slave_active,
    output logic irq
);
    // ==========================================================
    // Per-pin override resolution, returns {pull-up, enable, value}.
    function automatic logic [2:0] pin_ctl(input logic dir, input logic out,
        input logic global_pullup_disable, input logic puoe, input logic puov, input logic ddoe,
        input logic direction_override_value, input logic pvoe, input logic value_override_value);
        logic pu;
        logic oe;
        logic val;
        pu = puoe ? puov : (!dir && out && !global_pullup_disable);
        oe = ddoe ? direction_override_value : dir;
        val = oe ? (pvoe ? value_override_value : out) : 1'b0;
        return {pu, oe, val};
    endfunction

    pbmux_state_t st_q;
    pbmux_state_t st_d;

    logic global_pullup_disable;
    logic clk7;
    logic clk6;
    logic spi_slv;
    logic spi_mst;
    logic [7:0] clk_pins;
    logic [7:0] puoe;
    logic [7:0] puov;
    logic [7:0] ddoe;
    logic [7:0] pvoe;
    logic [7:0] value_override_value;
    logic [7:0] rd_dir;
    logic [7:0] rd_out;
    logic [7:0] rd_in;
    logic [7:0] events;
    logic [2:0] ctl;
    logic mapped;
    logic wr_en;

    // ==========================================================
    // Alternate function selection.
    always_comb begin
        global_pullup_disable = st_q.mcu[PBMUX_BIT_PULLUP_DISABLE];
        // Crystal needs both pins; an external clock only takes bit 6.
        clk7 = (!clk_src_int_rc && !clk_src_ext_clock)
            || (clk_src_int_rc && async_timer_select && !external_timer_clock_select);
        clk6 = !clk_src_int_rc || (clk_src_int_rc && async_timer_select);
        spi_slv = spi_enable && !spi_master;
        spi_mst = spi_enable && spi_master;
        clk_pins = '0;
        clk_pins[PBMUX_PIN_OSC_OUT] = clk7;
        clk_pins[PBMUX_PIN_OSC_IN] = clk6;
        puoe = '0;
        puov = '0;
        ddoe = '0;
        pvoe = '0;
        value_override_value = '0;
        // Clock pins: driver, pull-up and value all forced off.
        puoe = clk_pins;
        ddoe = clk_pins;
        // SPI forced inputs, pull-up still from the output bit.
        puoe[PBMUX_PIN_SCK] = spi_slv;
        ddoe[PBMUX_PIN_SCK] = spi_slv;
        puoe[PBMUX_PIN_MISO] = spi_mst;
        ddoe[PBMUX_PIN_MISO] = spi_mst;
        puoe[PBMUX_PIN_MOSI] = spi_slv;
        ddoe[PBMUX_PIN_MOSI] = spi_slv;
        puoe[PBMUX_PIN_SEL] = spi_slv;
        ddoe[PBMUX_PIN_SEL] = spi_slv;
        for (int i = PBMUX_PIN_SEL; i <= PBMUX_PIN_SCK; i++) begin
            puov[i] = st_q.out[i] && !global_pullup_disable;
        end
        // Value overrides act only where the direction bit drives.
        pvoe[PBMUX_PIN_SCK] = spi_mst;
        value_override_value[PBMUX_PIN_SCK] = spi_sck_out;
        pvoe[PBMUX_PIN_MISO] = spi_slv;
        value_override_value[PBMUX_PIN_MISO] = spi_slave_out;
        pvoe[PBMUX_PIN_MOSI] = spi_mst || timer2_cmp_a_en;
        value_override_value[PBMUX_PIN_MOSI] = (spi_mst && spi_master_out)
            || (timer2_cmp_a_en && timer2_cmp_a_out);
        pvoe[PBMUX_PIN_SEL] = timer1_cmp_b_en;
        value_override_value[PBMUX_PIN_SEL] = timer1_cmp_b_out;
        pvoe[PBMUX_PIN_CMP1A] = timer1_cmp_a_en;
        value_override_value[PBMUX_PIN_CMP1A] = timer1_cmp_a_out;
        // Register bits of a clock pin read as zero.
        rd_dir = st_q.dir & ~clk_pins;
        rd_out = st_q.out & ~clk_pins;
        rd_in = st_q.pin & ~clk_pins;
    end

    // ==========================================================
    // Next state.
    always_comb begin
        st_d = st_q;
        ctl = '0;
        for (int i = 0; i < PBMUX_NUM_PINS; i++) begin
            ctl = pin_ctl(st_q.dir[i], st_q.out[i], global_pullup_disable, puoe[i], 1'b0 | puov[i],
                ddoe[i], 1'b0, pvoe[i], value_override_value[i]);
            st_d.pad_pu[i] = ctl[2] && !global_pullup_disable;
            st_d.pad_oe[i] = ctl[1];
            st_d.pad_out[i] = ctl[0];
        end
        // Inputs are synchronous to pclk, one stage feeds pin change.
        st_d.pin = pad_in;
        events = st_q.pin ^ pad_in;
        st_d.spi_slave_active = spi_slv && !pad_in[PBMUX_PIN_SEL] && !clk_pins[PBMUX_PIN_SEL];
        // Zero-wait APB: data is prepared in setup, pready in access.
        mapped = (paddr == PBMUX_OFF_MCU_CONTROL) || (paddr == PBMUX_OFF_DIR)
            || (paddr == PBMUX_OFF_OUT) || (paddr == PBMUX_OFF_IN)
            || (paddr == PBMUX_OFF_IRQ_STATUS) || (paddr == PBMUX_OFF_IRQ_MASK);
        wr_en = psel && penable && st_q.pready && pwrite && mapped;
        st_d.pready = psel && !penable;
        st_d.pslverr = psel && !penable && !mapped;
        st_d.prdata = PBMUX_WORD_ZERO;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                PBMUX_OFF_MCU_CONTROL: st_d.prdata[7:0] = st_q.mcu;
                PBMUX_OFF_DIR: st_d.prdata[7:0] = rd_dir;
                PBMUX_OFF_OUT: st_d.prdata[7:0] = rd_out;
                PBMUX_OFF_IN: st_d.prdata[7:0] = rd_in;
                PBMUX_OFF_IRQ_STATUS: st_d.prdata[7:0] = st_q.irq_sts;
                PBMUX_OFF_IRQ_MASK: st_d.prdata[7:0] = st_q.irq_mask;
                default: st_d.prdata = PBMUX_WORD_ZERO;
            endcase
        end
        if (wr_en) begin
            case (paddr)
                PBMUX_OFF_MCU_CONTROL: st_d.mcu = pwdata[7:0] & PBMUX_MCU_WMASK;
                PBMUX_OFF_DIR: st_d.dir = pwdata[7:0];
                PBMUX_OFF_OUT: st_d.out = pwdata[7:0];
                PBMUX_OFF_IRQ_STATUS: st_d.irq_sts = st_q.irq_sts & ~pwdata[7:0];
                PBMUX_OFF_IRQ_MASK: st_d.irq_mask = pwdata[7:0];
                default: st_d.mcu = st_q.mcu;
            endcase
        end
        // A change in the clearing cycle still sets its bit.
        st_d.irq_sts = st_d.irq_sts | events;
        st_d.irq = |(st_d.irq_sts & st_d.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs.
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign pad_out = st_q.pad_out;
    assign pad_oe = st_q.pad_oe;
    assign pad_pullup = st_q.pad_pu;
    assign pin_change_src = st_q.pin;
    assign spi_slave_active = st_q.spi_slave_active;
    assign irq = st_q.irq;

    // ==========================================================
    // Checks.
    AST_PUD_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        $past(st_q.mcu[PBMUX_BIT_PULLUP_DISABLE]) |-> pad_pullup == 8'h00)
        else $error("pull-up on while disabled");
    AST_CLK7_FREE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(clk7) |-> !pad_oe[PBMUX_PIN_OSC_OUT] && !pad_pullup[PBMUX_PIN_OSC_OUT])
        else $error("bit 7 driven while clock pin");
    AST_CLK6_FREE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!clk_src_int_rc) |-> !pad_oe[PBMUX_PIN_OSC_IN])
        else $error("bit 6 driven while oscillator input");
    AST_TOSC: assert property (@(posedge pclk) disable iff (!presetn)
        $past(clk_src_int_rc && async_timer_select && st_q.dir[PBMUX_PIN_OSC_IN])
        |-> !pad_oe[PBMUX_PIN_OSC_IN])
        else $error("bit 6 driven in timer oscillator mode");
    AST_CLK_READ: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == PBMUX_OFF_DIR && clk6
        |=> !prdata[PBMUX_PIN_OSC_IN])
        else $error("clock pin direction bit reads one");
    AST_SCK_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && !spi_master) |-> !pad_oe[PBMUX_PIN_SCK])
        else $error("clock pin driven as slave");
    AST_MISO_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && spi_master) |-> !pad_oe[PBMUX_PIN_MISO])
        else $error("MISO driven as master");
    AST_SEL_PU: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && !spi_master && st_q.out[PBMUX_PIN_SEL] && !global_pullup_disable)
        |-> pad_pullup[PBMUX_PIN_SEL])
        else $error("select pull-up lost");
    AST_CMP_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        $past(timer1_cmp_a_en && st_q.dir[PBMUX_PIN_CMP1A])
        |-> pad_oe[PBMUX_PIN_CMP1A] && pad_out[PBMUX_PIN_CMP1A] == $past(timer1_cmp_a_out))
        else $error("compare output not on pad");
    AST_PCHG: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pin_change_src == $past(pad_in))
        else $error("pin change source lags");
    AST_SLV_ACT: assert property (@(posedge pclk) disable iff (!presetn)
        spi_slave_active |-> $past(!pad_in[PBMUX_PIN_SEL] && spi_enable && !spi_master))
        else $error("slave active without select low");

    // ==========================================================
    // Checks on override resolution and the register side.
    AST_TOSC_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        $past(clk_src_int_rc && async_timer_select && !external_timer_clock_select)
        |-> !pad_oe[PBMUX_PIN_OSC_OUT] && !pad_pullup[PBMUX_PIN_OSC_OUT])
        else $error("bit 7 driven in timer oscillator mode");
    AST_GPIO_HI: assert property (@(posedge pclk) disable iff (!presetn)
        $past(clk_src_int_rc && !async_timer_select)
        |-> pad_oe[PBMUX_PIN_OSC_OUT:PBMUX_PIN_OSC_IN]
            == $past(st_q.dir[PBMUX_PIN_OSC_OUT:PBMUX_PIN_OSC_IN]))
        else $error("upper pins not general I/O");
    AST_CLK6_PU: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!clk_src_int_rc) |-> !pad_pullup[PBMUX_PIN_OSC_IN])
        else $error("bit 6 pull-up on while oscillator input");
    AST_CLK_READ_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == PBMUX_OFF_OUT && clk7
        |=> !prdata[PBMUX_PIN_OSC_OUT])
        else $error("clock pin output bit reads one");
    AST_CLK_READ_IN: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == PBMUX_OFF_IN && clk6
        |=> !prdata[PBMUX_PIN_OSC_IN])
        else $error("clock pin input bit reads one");
    AST_SCK_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && spi_master)
        |-> pad_oe[PBMUX_PIN_SCK] == $past(st_q.dir[PBMUX_PIN_SCK]))
        else $error("clock pin ignores direction as master");
    AST_MISO_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && !spi_master)
        |-> pad_oe[PBMUX_PIN_MISO] == $past(st_q.dir[PBMUX_PIN_MISO]))
        else $error("MISO ignores direction as slave");
    AST_MOSI_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && !spi_master) |-> !pad_oe[PBMUX_PIN_MOSI])
        else $error("MOSI driven as slave");
    AST_MOSI_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && spi_master)
        |-> pad_oe[PBMUX_PIN_MOSI] == $past(st_q.dir[PBMUX_PIN_MOSI]))
        else $error("MOSI ignores direction as master");
    AST_SEL_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && !spi_master) |-> !pad_oe[PBMUX_PIN_SEL])
        else $error("select pin driven as slave");
    AST_SEL_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && spi_master)
        |-> pad_oe[PBMUX_PIN_SEL] == $past(st_q.dir[PBMUX_PIN_SEL]))
        else $error("select pin ignores direction as master");
    AST_SLV_SET: assert property (@(posedge pclk) disable iff (!presetn)
        spi_enable && !spi_master && !pad_in[PBMUX_PIN_SEL] |=> spi_slave_active)
        else $error("slave not active with select low");
    AST_MISO_PU: assert property (@(posedge pclk) disable iff (!presetn)
        $past(spi_enable && spi_master)
        |-> pad_pullup[PBMUX_PIN_MISO] == $past(st_q.out[PBMUX_PIN_MISO] && !global_pullup_disable))
        else $error("MISO pull-up not from output bit");
    AST_CMP2A: assert property (@(posedge pclk) disable iff (!presetn)
        $past(timer2_cmp_a_en && !spi_enable && st_q.dir[PBMUX_PIN_MOSI])
        |-> pad_out[PBMUX_PIN_MOSI] == $past(timer2_cmp_a_out))
        else $error("timer 2 compare output not on pad");
    AST_CMP_NODIR: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!st_q.dir[PBMUX_PIN_CMP1A]) |-> !pad_oe[PBMUX_PIN_CMP1A] && !pad_out[PBMUX_PIN_CMP1A])
        else $error("compare output driven without direction");
    AST_PIN_EVT: assert property (@(posedge pclk) disable iff (!presetn)
        |(st_q.pin ^ pad_in)
        |=> (st_q.irq_sts & $past(st_q.pin ^ pad_in)) == $past(st_q.pin ^ pad_in))
        else $error("pin change not recorded");
    AST_PU_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!spi_enable && !clk7 && !clk6)
        |-> pad_pullup == $past(~st_q.dir & st_q.out & ~{8{global_pullup_disable}}))
        else $error("default pull-up wrong");
    AST_DIR_OVR: assert property (@(posedge pclk) disable iff (!presetn)
        $past(clk6 && st_q.dir[PBMUX_PIN_OSC_IN]) |-> !pad_oe[PBMUX_PIN_OSC_IN])
        else $error("direction override ignored");
    AST_VAL_OVR: assert property (@(posedge pclk) disable iff (!presetn)
        $past(timer1_cmp_b_en && !spi_enable && st_q.dir[PBMUX_PIN_SEL])
        |-> pad_out[PBMUX_PIN_SEL] == $past(timer1_cmp_b_out))
        else $error("value override ignored");
    AST_VAL_PLAIN: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!timer1_cmp_a_en && st_q.dir[PBMUX_PIN_CMP1A])
        |-> pad_out[PBMUX_PIN_CMP1A] == $past(st_q.out[PBMUX_PIN_CMP1A]))
        else $error("pad value not from output bit");
    AST_SPI_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!spi_enable)
        |-> pad_oe[PBMUX_PIN_SCK:PBMUX_PIN_SEL] == $past(st_q.dir[PBMUX_PIN_SCK:PBMUX_PIN_SEL]))
        else $error("SPI override while disabled");
endmodule
`default_nettype wire

// *** pbmux_partner.sv ***
// Behavioural model of the on-chip clock, SPI and timer sources of the port B mux.
`timescale 1ns/10ps
`default_nettype none
module pbmux_partner (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Requested settings, one bit per source line.
    input wire logic [15:0] cfg,
    // Source levels.
    output logic [14:0] src
);
    // ==========================================================
    // Sources change only after a clock edge, as the on-chip logic does.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src <= 15'h0001;
        end else begin
            // The timer never claims the pin while SPI masters it, so the value is defined.
            src <= {cfg[14:10], cfg[9] & ~(cfg[4] & cfg[5]), cfg[8:0]};
        end
    end
endmodule
`default_nettype wire

// *** pbmux_test.sv ***
// Self-checking testbench of the port B alternate function mux.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module pbmux_test;
    import pbmux_pkg::*;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, ssa, irq;
    logic [7:0] paddr, pad_in, pad_out, pad_oe, pad_pullup, pcs;
    logic [31:0] pwdata, prdata, seed, r, w, rd, e;
    logic [15:0] cfg;
    logic [14:0] src;
    logic [7:0] old;
    logic er;
    int n_errors, compares;
    logic [15:0] corner [5] = '{16'h0011, 16'h0031, 16'h0000, 16'h0005, 16'h000d};
    always #4 pclk = ~pclk;
    pbmux_partner u_pbmux_partner (.pclk(pclk), .presetn(presetn), .cfg(cfg), .src(src));
    pbmux_top u_pbmux_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_src_int_rc(src[0]), .clk_src_ext_clock(src[1]),
        .async_timer_select(src[2]), .external_timer_clock_select(src[3]),
        .spi_enable(src[4]), .spi_master(src[5]), .spi_sck_out(src[6]),
        .spi_slave_out(src[7]), .spi_master_out(src[8]), .timer2_cmp_a_en(src[9]),
        .timer2_cmp_a_out(src[10]), .timer1_cmp_b_en(src[11]), .timer1_cmp_b_out(src[12]),
        .timer1_cmp_a_en(src[13]), .timer1_cmp_a_out(src[14]), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .pin_change_src(pcs), .spi_slave_active(ssa), .irq(irq));
    // ==========================================================
    // Helpers.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Returns clock-pin mask, drive enables, driven values and pull-ups.
    function automatic logic [31:0] exp_pads(input logic [14:0] s, input logic [7:0] d,
                                             input logic [7:0] o, input logic global_pullup_disable);
        logic [7:0] ck, dd, pe, pvv, op;
        logic ms, sl;
        ms = s[4] & s[5];
        sl = s[4] & ~s[5];
        ck = {(~s[0] & ~s[1]) | (s[0] & s[2] & ~s[3]), ~s[0] | (s[0] & s[2]), 6'h00};
        dd = ck | {2'b00, sl, ms, sl, sl, 2'b00};
        pe = {2'b00, ms, sl, ms | s[9], s[11], s[13], 1'b0};
        pvv = {2'b00, s[6], s[7], ms ? s[8] : s[10], s[12], s[14], 1'b0};
        op = o & {8{~global_pullup_disable}};
        return {ck, ~dd & d, (pe & pvv) | (~pe & o), (dd & op & ~ck) | (~dd & ~d & op)};
    endfunction
    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        n_errors = 0;
        compares = 0;
        seed = 32'h7e11;
        {presetn, psel, penable, pwrite, paddr, pwdata, pad_in} = '0;
        cfg = 16'h0001;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), PBMUX_WORD_ZERO);
            `CHK("reset value", PBMUX_WORD_ZERO, rd)
        end
        apb(1'b1, PBMUX_OFF_MCU_CONTROL, 32'hffff_ffff);
        apb(1'b0, PBMUX_OFF_MCU_CONTROL, PBMUX_WORD_ZERO);
        `CHK("mcu_control", {24'h0, PBMUX_MCU_WMASK}, rd)
        apb(1'b1, 8'h18, 32'h0000_00a5);
        `CHK("unmapped err", 1'b1, er)
        apb(1'b0, 8'h18, PBMUX_WORD_ZERO);
        `CHK("unmapped data", PBMUX_WORD_ZERO, rd)
        // Corner settings first: SPI slave, SPI master, crystal, timer crystal, timer clock.
        for (int k = 0; k < 45; k++) begin
            r = rnd();
            w = rnd();
            cfg <= (k < 5) ? corner[k] : r[15:0];
            pad_in <= r[23:16];
            apb(1'b1, PBMUX_OFF_DIR, {24'h0, w[7:0]});
            apb(1'b1, PBMUX_OFF_OUT, {24'h0, w[15:8]});
            apb(1'b1, PBMUX_OFF_MCU_CONTROL, {24'h0, w[23:16] & {3'h7, k > 4, 4'hf}});
            repeat (3) @(posedge pclk);
            #1;
            e = exp_pads(src, w[7:0], w[15:8], w[20] && k > 4);
            `CHK("pad_oe", e[23:16], pad_oe)
            `CHK("pad_out", e[15:8] & e[23:16], pad_out)
            `CHK("pad_pullup", e[7:0], pad_pullup)
            `CHK("pin_change_src", pad_in, pcs)
            `CHK("slave_active", src[4] & ~src[5] & ~pad_in[2], ssa)
            apb(1'b1, PBMUX_OFF_IN, 32'h0000_00ff);
            apb(1'b0, PBMUX_OFF_IN, PBMUX_WORD_ZERO);
            `CHK("in", {24'h0, pad_in & ~e[31:24]}, rd)
            apb(1'b0, PBMUX_OFF_DIR, PBMUX_WORD_ZERO);
            `CHK("dir", {24'h0, w[7:0] & ~e[31:24]}, rd)
            apb(1'b0, PBMUX_OFF_OUT, PBMUX_WORD_ZERO);
            `CHK("out", {24'h0, w[15:8] & ~e[31:24]}, rd)
        end
        // Pin change events, masking and write-one-to-clear.
        cfg <= 16'h0001;
        repeat (3) @(posedge pclk);
        apb(1'b1, PBMUX_OFF_IRQ_STATUS, 32'h0000_00ff);
        for (int k = 0; k < 20; k++) begin
            r = rnd();
            apb(1'b1, PBMUX_OFF_IRQ_MASK, {24'h0, r[15:8]});
            old = pad_in;
            pad_in <= r[7:0];
            repeat (3) @(posedge pclk);
            apb(1'b0, PBMUX_OFF_IRQ_STATUS, PBMUX_WORD_ZERO);
            `CHK("irq_status", {24'h0, old ^ r[7:0]}, rd)
            `CHK("irq", |((old ^ r[7:0]) & r[15:8]), irq)
            apb(1'b1, PBMUX_OFF_IRQ_STATUS, 32'h0000_00ff);
            repeat (2) @(posedge pclk);
            #1;
            `CHK("irq cleared", 1'b0, irq)
        end
        give_verdict();
    end
endmodule
`default_nettype wire
